// [verilog/tipc_pkg.sv]
// Package for the timer interrupt enable/pending block.
// Assumes an APB slave with 32-bit data; registers are 8 bits wide.
package tipc_pkg;
  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [11:0] ADDR_ENABLE_PENDING = 12'h000;
  localparam logic [11:0] ADDR_CLEAR          = 12'h004;
  localparam int          NUM_SRC             = 4;
  localparam int          ENABLE_LSB          = 4;
  localparam logic [7:0]  CLEAR_READBACK      = 8'hFF;
  localparam logic [3:0]  FLAGS_RESET         = 4'h0;
  localparam logic [31:0] READ_ZERO           = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] irq_on;
    logic [3:0] flag;
  } tipc_ctl_t;
endpackage : tipc_pkg

// [verilog/tipc_flags.sv]
// Four pending flags with set and clear terms.
// Assumes synchronous active-low reset and clock enable from the top.
`timescale 1ns/100ps
module tipc_flags #(
  parameter int N = 4
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         ce_in,
  input  wire logic         timer_on_in,
  input  wire logic [N-1:0] set_in,
  input  wire logic [N-1:0] wipe_in,
  output logic      [N-1:0] flag_out
);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      flag_out <= '0;
    end else if (ce_in) begin
      if (!timer_on_in) begin
        flag_out <= '0;
      end else begin
        // Set beats clear in the same cycle so no event is lost
        flag_out <= (flag_out & ~wipe_in) | set_in;
      end
    end
  end

  a_flag_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && timer_on_in && (wipe_in == '0) |=> ((flag_out & $past(flag_out))
      == $past(flag_out))) else $error("pending flag lost");
endmodule : tipc_flags

// [verilog/tipc_top.sv]
// Timer interrupt enable/pending register block, APB slave.
// Assumes timer core supplies one-cycle condition strobes and timer enable.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
module tipc_top (
  input  wire logic        REF_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        CE_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  COND_IN,
  input  wire logic        TIMER_MODULE_ON_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic             TIMER_IRQ_OUT
);
  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  localparam int N = tipc_pkg::NUM_SRC;
  logic         setup;
  logic         wr_ctl;
  logic         wr_clr;
  logic         hit;
  logic [N-1:0] irq_on_reg;
  logic [N-1:0] flags;
  logic [N-1:0] set_next;
  logic [N-1:0] wipe_next;
  tipc_pkg::tipc_ctl_t ctl;

  // Zero-wait: answer in the access cycle right after setup
  assign setup  = PSEL_IN && !PENABLE_IN;
  assign hit    = (PADDR_IN == tipc_pkg::ADDR_ENABLE_PENDING)
               || (PADDR_IN == tipc_pkg::ADDR_CLEAR);
  assign wr_ctl = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
               && PADDR_IN == tipc_pkg::ADDR_ENABLE_PENDING;
  assign wr_clr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
               && PADDR_IN == tipc_pkg::ADDR_CLEAR;

  assign set_next  = COND_IN
                   | (wr_ctl ? PWDATA_IN[N-1:0] : '0);
  assign wipe_next = wr_clr ? PWDATA_IN[N-1:0] : '0;

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= tipc_pkg::READ_ZERO;
    end else if (CE_IN) begin
      PREADY_OUT  <= setup;
      PSLVERR_OUT <= setup && !hit;
      PRDATA_OUT  <= tipc_pkg::READ_ZERO;
      if (setup && !PWRITE_IN) begin
        if (PADDR_IN == tipc_pkg::ADDR_CLEAR)
          PRDATA_OUT[7:0] <= tipc_pkg::CLEAR_READBACK;
        else if (PADDR_IN == tipc_pkg::ADDR_ENABLE_PENDING)
          PRDATA_OUT[7:0] <= ctl;
      end
    end
  end

  // --------------------------------------------------------------------
  // Enables and request
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      irq_on_reg <= tipc_pkg::FLAGS_RESET;
    end else if (CE_IN && wr_ctl) begin
      irq_on_reg <= PWDATA_IN[tipc_pkg::ENABLE_LSB +: N];
    end
  end

  tipc_flags #(.N(N)) u_flags (
    .clk_in      (REF_CLK_IN),
    .nrst_in     (NRST_IN),
    .ce_in       (CE_IN),
    .timer_on_in (TIMER_MODULE_ON_IN),
    .set_in      (set_next),
    .wipe_in     (wipe_next),
    .flag_out    (flags)
  );

  assign ctl.irq_on = irq_on_reg;
  assign ctl.flag   = flags;

  // Registered request; lags the flags by one cycle
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      TIMER_IRQ_OUT <= 1'b0;
    end else if (CE_IN) begin
      TIMER_IRQ_OUT <= |(flags & irq_on_reg);
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_irq_follows: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN |=> TIMER_IRQ_OUT == $past(|(flags & irq_on_reg)))
    else $error("irq not matching enabled flags");
  a_irq_masked: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && (irq_on_reg == '0) |=> !TIMER_IRQ_OUT)
    else $error("irq with all enables off");
  a_zero_no_clear: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && TIMER_MODULE_ON_IN && !wr_clr |=> (flags & $past(flags))
      == $past(flags)) else $error("flag cleared without clear");
  a_sw_set: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && TIMER_MODULE_ON_IN && wr_ctl |=>
      (flags & $past(PWDATA_IN[N-1:0])) == $past(PWDATA_IN[N-1:0]))
    else $error("software set lost");
  a_clear_wipe: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && wr_clr && (COND_IN == '0) |=>
      (flags & $past(PWDATA_IN[N-1:0])) == '0)
    else $error("clear did not clear");
  a_off_clear: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && !TIMER_MODULE_ON_IN |=> flags == '0)
    else $error("flags kept while off");
  a_clr_readback: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && setup && !PWRITE_IN && PADDR_IN == tipc_pkg::ADDR_CLEAR |=>
      PRDATA_OUT[7:0] == tipc_pkg::CLEAR_READBACK)
    else $error("clear readback wrong");
  a_reset_state: assert property (@(posedge REF_CLK_IN)
    !NRST_IN |=> ctl == '0 && !TIMER_IRQ_OUT)
    else $error("reset state wrong");
  a_hw_set: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && TIMER_MODULE_ON_IN |=> (flags & $past(COND_IN)) == $past(COND_IN))
    else $error("condition not latched");
endmodule : tipc_top

// [test/tipc_top_bench.sv]
// Self-checking bench for the timer interrupt enable/pending block.
// Assumes tipc_top answers APB with zero wait states, outputs registered.
`timescale 1ns/100ps
module tipc_top_bench;
  logic        clk, nrst, ce, psel, pen, pwr, ton, pready, serr, irq, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  cond;
  int          err_total, checks_done, i;
  localparam logic [11:0] CTL = tipc_pkg::ADDR_ENABLE_PENDING;
  localparam logic [11:0] CLR = tipc_pkg::ADDR_CLEAR;

  tipc_top u_tipc_top (.REF_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .COND_IN(cond), .TIMER_MODULE_ON_IN(ton),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(serr),
    .TIMER_IRQ_OUT(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task conclude;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  // Idle edge first, so release and next setup never share a step.
  // Answer is sampled mid-cycle, where it stands settled, then released
  // at the following rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(negedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      err_total++;
      conclude();
    end
    rd = prdata;
    se = serr;
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rd);
  endtask : rdc
  // Request lags the flags by one cycle
  task irqc(input logic e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : irqc
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0; ce = 1'b1; ton = 1'b1; psel = 1'b0; pen = 1'b0;
    pwr = 1'b0; paddr = 12'h000; pwdata = 32'h0; cond = 4'h0;
    err_total = 0; checks_done = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rdc(CTL, 32'h0);
    rdc(CLR, 32'h0000_00FF);
    chk("slverr", 32'h0, {31'h0, se});
    apb(1'b1, CTL, 32'h0F); rdc(CTL, 32'h0F);
    irqc(1'b0);
    apb(1'b1, CTL, 32'hF0); rdc(CTL, 32'hFF);
    irqc(1'b1);
    // Clear register only ever written whole, never read-modified
    apb(1'b1, CLR, 32'hF5); rdc(CTL, 32'hFA);
    apb(1'b1, CLR, 32'h0); rdc(CTL, 32'hFA);
    apb(1'b1, CLR, 32'h0A); rdc(CTL, 32'hF0);
    irqc(1'b0);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      cond <= 4'h1 << i;
      @(posedge clk);
      cond <= 4'h0;
      rdc(CTL, 32'hF0 | (32'h1 << i));
      irqc(1'b1);
      apb(1'b1, CLR, 32'h1 << i);
    end
    apb(1'b1, CTL, 32'h0);
    @(posedge clk);
    cond <= 4'h1;
    @(posedge clk);
    cond <= 4'h0;
    rdc(CTL, 32'h01);
    irqc(1'b0);
    @(posedge clk);
    ton <= 1'b0;
    apb(1'b1, CTL, 32'h0F); rdc(CTL, 32'h0);
    ton <= 1'b1;
    apb(1'b1, 12'h008, 32'h0F);
    chk("slverr", 32'h1, {31'h0, se});
    rdc(CTL, 32'h0);
    conclude();
  end
endmodule : tipc_top_bench
